// ===== dv/audio_src.sv
// Audio clock source model driving MCLK, SCLK and LRCLK frames.
// Assumes a 200 MHz i_clk_sys; all clocks stand low between frames.
`timescale 1ns/1ps
module audio_src (
	input wire logic i_clk_sys,
	output logic o_mclk,
	output logic o_sclk,
	output logic o_lrclk
);
	initial begin
		o_mclk = 1'b0;
		o_sclk = 1'b0;
		o_lrclk = 1'b0;
	end
	// One frame of n MCLK; SCLK half period is h MCLK, never 1 FS
	task automatic frame(input int n, input int h);
		for (int i = 0; i < n; i++) begin
			@(posedge i_clk_sys);
			o_mclk <= 1'b1;
			o_lrclk <= (i < n / 2);
			o_sclk <= ((i / h) % 2 == 1);
			repeat (3) @(posedge i_clk_sys);
			o_mclk <= 1'b0;
			repeat (2) @(posedge i_clk_sys);
		end
		o_sclk <= 1'b0;
	endtask
endmodule

// ===== dv/clk_det_chk.sv
// Checker for the clock detector status ports.
// Bound onto clk_det_status; one clock domain, i_ce low only
// briefly while the audio clocks stand idle.
`timescale 1ns/1ps
module clk_det_chk (
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	input wire logic i_mclk,
	input wire logic i_sclk,
	input wire logic i_lrclk,
	input wire logic i_pll_enable,
	input wire logic i_pll_locked,
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	input wire logic [7:0] o_reg_rdata,
	input wire logic [3:0] o_mclk_ratio_code
);
	logic mclk_q;
	logic [7:0] quiet_q;
	logic [3:0] lock_q;
	logic [1:0] live_q;
	logic lr_q;
	logic [12:0] mcnt_q;
	wire m_rise = i_mclk && !mclk_q;
	wire lr_rise = i_lrclk && !lr_q;
	wire rd_take = i_ce && i_reg_rd;
	wire rd_stat = rd_take && i_reg_addr == 8'h5E;
	default clocking cb @(posedge i_clk_sys);
	endclocking
	default disable iff (i_sys_rst);
	// Cycles since the last raw MCLK rise, saturating
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mclk_q <= 1'b0;
			quiet_q <= 8'hFF;
			live_q <= 2'h0;
		end else begin
			mclk_q <= i_mclk;
			// Rises since the last gap long enough to look halted
			if (m_rise) begin
				quiet_q <= 8'h00;
				if (quiet_q >= 8'hC0)
					live_q <= 2'h1;
				else if (live_q != 2'h3)
					live_q <= live_q + 2'h1;
			end else begin
				if (quiet_q != 8'hFF)
					quiet_q <= quiet_q + 8'h01;
				if (quiet_q >= 8'hC0)
					live_q <= 2'h0;
			end
		end
	end
	// Raw MCLK rises per LRCLK period, frame-start rise counted first
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			lr_q <= 1'b0;
			mcnt_q <= 13'h0000;
		end else begin
			lr_q <= i_lrclk;
			if (lr_rise)
				mcnt_q <= {12'h000, m_rise};
			else if (m_rise && mcnt_q != 13'h1FFF)
				mcnt_q <= mcnt_q + 13'h0001;
		end
	end
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst)
			lock_q <= 4'h0;
		else if (!(i_pll_enable && i_pll_locked))
			lock_q <= 4'h0;
		else if (lock_q != 4'hF)
			lock_q <= lock_q + 4'h1;
	end
	a_code_legal: assert property (o_mclk_ratio_code != 4'hF)
		else $error("ratio code out of range");
	a_rdata_stands: assert property (!rd_take |=> $stable(o_reg_rdata))
		else $error("read data moved without a read");
	a_unmapped_zero: assert property (rd_take && (i_reg_addr < 8'h5C ||
		i_reg_addr > 8'h5E) |=> o_reg_rdata == 8'h00)
		else $error("unmapped read not zero");
	a_code_frame: assert property ($stable(i_lrclk) [*8] |=>
		$stable(o_mclk_ratio_code))
		else $error("ratio code moved inside a frame");
	a_halt_set: assert property (rd_stat && quiet_q > 8'hF9 |=>
		o_reg_rdata[6])
		else $error("halted MCLK not flagged");
	a_halt_clear: assert property (rd_stat && live_q > 2'h1 &&
		quiet_q < 8'h96 |=> !o_reg_rdata[6])
		else $error("running MCLK flagged missing");
	a_code_512: assert property (lr_rise && mcnt_q == 13'h0200 |->
		##[5:7] o_mclk_ratio_code == 4'h8)
		else $error("512 MCLK frame gave wrong code");
	a_code_3072: assert property (lr_rise && mcnt_q == 13'h0C00 |->
		##[5:7] o_mclk_ratio_code == 4'hE)
		else $error("3072 MCLK frame gave wrong code");
	a_code_bad: assert property (lr_rise && mcnt_q == 13'h0280 |->
		##[5:7] o_mclk_ratio_code == 4'h0)
		else $error("unlisted ratio not coded as error");
	a_pll_off: assert property (rd_stat && !i_pll_enable &&
		!$past(i_pll_enable) |=> o_reg_rdata[5])
		else $error("disabled PLL not flagged");
	a_pll_lock: assert property (rd_stat && lock_q > 4'hB |=>
		!o_reg_rdata[5])
		else $error("locked PLL flagged unlocked");
	c_stat: cover property (rd_stat);
	c_code: cover property (o_mclk_ratio_code == 4'h8);
	c_halt: cover property (rd_stat && quiet_q == 8'hFF);
	c_frame: cover property (lr_rise && mcnt_q == 13'h0C00);
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the clock detector status block.
// Inputs change at the falling edge; audio_src makes the clocks.
`timescale 1ns/1ps
module tb_top;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic ce = 1'b1;
	logic pll_en = 1'b0;
	logic pll_lk = 1'b0;
	logic [7:0] addr = 8'h00;
	logic wr = 1'b0;
	logic [7:0] wdata = 8'h00;
	logic rd = 1'b0;
	logic [7:0] rdata;
	logic [3:0] code;
	logic mclk;
	logic sclk;
	logic lrclk;
	int n_mismatch = 0;
	int samples_checked = 0;
	always #2.5 clk = ~clk;
	audio_src src (.i_clk_sys(clk), .o_mclk(mclk), .o_sclk(sclk),
		.o_lrclk(lrclk));
	clk_det_status dut (.i_clk_sys(clk), .i_sys_rst(rst), .i_ce(ce),
		.i_mclk(mclk), .i_sclk(sclk), .i_lrclk(lrclk),
		.i_pll_enable(pll_en), .i_pll_locked(pll_lk),
		.i_reg_addr(addr), .i_reg_wr(wr), .i_reg_wdata(wdata),
		.i_reg_rd(rd), .o_reg_rdata(rdata), .o_mclk_ratio_code(code));
	task automatic chk(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic close_out;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic wreg(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(negedge clk);
		wr = 1'b0;
	endtask
	// Read one register, compare the bits under mask
	task automatic rchk(input string nm, input logic [7:0] a,
		input logic [7:0] m, input logic [7:0] exp);
		@(negedge clk);
		addr = a;
		rd = 1'b1;
		@(negedge clk);
		rd = 1'b0;
		chk(nm, rdata & m, exp);
	endtask
	task automatic t_reset;
		rchk("stat", 8'h5E, 8'hFF, 8'h60);
		rchk("high", 8'h5C, 8'hFF, 8'h00);
		rchk("low", 8'h5D, 8'hFF, 8'h00);
		rchk("unmapped", 8'h7F, 8'hFF, 8'h00);
		chk("code", {4'h0, code}, 8'h00);
	endtask
	task automatic t_pll;
		pll_en = 1'b1;
		repeat (12) @(negedge clk);
		rchk("unlock", 8'h5E, 8'h20, 8'h20);
		pll_lk = 1'b1;
		repeat (12) @(negedge clk);
		rchk("lock", 8'h5E, 8'h20, 8'h00);
		pll_en = 1'b0;
		repeat (3) @(negedge clk);
		rchk("disabled", 8'h5E, 8'h20, 8'h20);
		pll_en = 1'b1;
	endtask
	// Each frame's result but the last is judged while the next frame runs
	task automatic t_ratios;
		int nm[11] = '{512, 512, 768, 1024, 1152, 1536, 2048, 3072, 640,
			512, 512};
		logic [3:0] ec[11] = '{4'h8, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD,
			4'hE, 4'h0, 4'h8, 4'h8};
		for (int k = 0; k < 11; k++) begin
			fork
				src.frame(nm[k], (k == 9) ? 1 : nm[k] / 128);
				begin
					repeat (30) @(negedge clk);
					if (k > 0)
						chk("code", {4'h0, code}, {4'h0, ec[k - 1]});
					if (k == 1) begin
						wreg(8'h5D, 8'hFF);
						rchk("low", 8'h5D, 8'hFF, 8'h40);
						rchk("high", 8'h5C, 8'hFF, 8'h00);
					end
					if (k == 2)
						rchk("present", 8'h5E, 8'h40, 8'h00);
					if (k == 10) begin
						wreg(8'h5C, 8'hFE);
						rchk("high", 8'h5C, 8'hFF, 8'hFF);
						rchk("low", 8'h5D, 8'hFF, 8'h00);
					end
				end
			join
		end
	endtask
	task automatic t_halt;
		repeat (250) @(negedge clk);
		rchk("halted", 8'h5E, 8'h40, 8'h40);
	endtask
	// Mid-run reset must clear code and reserved bits; i_ce low must
	// keep a write from landing
	task automatic t_rerst;
		wreg(8'h5E, 8'h80);
		rchk("rsv", 8'h5E, 8'h80, 8'h80);
		@(negedge clk);
		rst = 1'b1;
		repeat (8) @(negedge clk);
		rst = 1'b0;
		chk("code", {4'h0, code}, 8'h00);
		repeat (12) @(negedge clk);
		rchk("high", 8'h5C, 8'hFF, 8'h00);
		rchk("stat", 8'h5E, 8'hFF, 8'h40);
		ce = 1'b0;
		wreg(8'h5C, 8'hFE);
		ce = 1'b1;
		rchk("frozen", 8'h5C, 8'hFF, 8'h00);
	endtask
	initial begin
		repeat (8) @(negedge clk);
		rst = 1'b0;
		t_reset();
		t_pll();
		t_ratios();
		t_halt();
		t_rerst();
		close_out();
	end
	// Whole run needs about 74000 cycles
	initial begin
		repeat (90000) @(posedge clk);
		n_mismatch++;
		close_out();
	end
endmodule
bind clk_det_status clk_det_chk chk (.i_clk_sys(i_clk_sys),
	.i_sys_rst(i_sys_rst), .i_ce(i_ce), .i_mclk(i_mclk), .i_sclk(i_sclk),
	.i_lrclk(i_lrclk), .i_pll_enable(i_pll_enable),
	.i_pll_locked(i_pll_locked), .i_reg_addr(i_reg_addr),
	.i_reg_wr(i_reg_wr), .i_reg_wdata(i_reg_wdata), .i_reg_rd(i_reg_rd),
	.o_reg_rdata(o_reg_rdata), .o_mclk_ratio_code(o_mclk_ratio_code));

// ===== rtl/clk_det_pkg.sv
// Constants for the audio clock detector status block.
// Assumes a 200 MHz system clock and an 8-bit register port.
package clk_det_pkg;
	// Register offsets
	localparam logic [7:0] REG_BCLK_RATIO_HIGH = 8'h5C;
	localparam logic [7:0] REG_BCLK_RATIO_LOW = 8'h5D;
	localparam logic [7:0] REG_CLOCK_DET_STATUS = 8'h5E;

	// Field positions and widths
	localparam int BCLK_MSB_BIT = 0;
	localparam int MCLK_MISSING_BIT = 6;
	localparam int PLL_UNLOCKED_BIT = 5;
	localparam int RATIO_CODE_BITS = 4;
	localparam int BCLK_COUNT_BITS = 9;
	localparam int MCLK_COUNT_BITS = 13;

	// Reset values
	localparam logic [7:0] RESERVED_RST = 8'h00;
	localparam logic [3:0] RATIO_CODE_RST = 4'h0;
	localparam logic [8:0] BCLK_COUNT_RST = 9'h000;
	localparam logic [12:0] MCLK_COUNT_RST = 13'h0000;

	// Master clock ratio codes
	localparam logic [3:0] CODE_ERROR = 4'h0;
	localparam logic [3:0] CODE_32 = 4'h1;
	localparam logic [3:0] CODE_48 = 4'h2;
	localparam logic [3:0] CODE_64 = 4'h3;
	localparam logic [3:0] CODE_128 = 4'h4;
	localparam logic [3:0] CODE_192 = 4'h5;
	localparam logic [3:0] CODE_256 = 4'h6;
	localparam logic [3:0] CODE_384 = 4'h7;
	localparam logic [3:0] CODE_512 = 4'h8;
	localparam logic [3:0] CODE_768 = 4'h9;
	localparam logic [3:0] CODE_1024 = 4'hA;
	localparam logic [3:0] CODE_1152 = 4'hB;
	localparam logic [3:0] CODE_1536 = 4'hC;
	localparam logic [3:0] CODE_2048 = 4'hD;
	localparam logic [3:0] CODE_3072 = 4'hE;

	// Master clocks per frame for each code
	localparam logic [12:0] RATIO_32 = 13'h0020;
	localparam logic [12:0] RATIO_48 = 13'h0030;
	localparam logic [12:0] RATIO_64 = 13'h0040;
	localparam logic [12:0] RATIO_128 = 13'h0080;
	localparam logic [12:0] RATIO_192 = 13'h00C0;
	localparam logic [12:0] RATIO_256 = 13'h0100;
	localparam logic [12:0] RATIO_384 = 13'h0180;
	localparam logic [12:0] RATIO_512 = 13'h0200;
	localparam logic [12:0] RATIO_768 = 13'h0300;
	localparam logic [12:0] RATIO_1024 = 13'h0400;
	localparam logic [12:0] RATIO_1152 = 13'h0480;
	localparam logic [12:0] RATIO_1536 = 13'h0600;
	localparam logic [12:0] RATIO_2048 = 13'h0800;
	localparam logic [12:0] RATIO_3072 = 13'h0C00;

	// Master clock halt detection time
	localparam int SYS_CLK_MHZ = 200;
	localparam int MCLK_HALT_NS = 1000;
	localparam int MCLK_HALT_CYCLES = (MCLK_HALT_NS * SYS_CLK_MHZ) / 1000;
	localparam int HALT_COUNT_BITS = 8;
	localparam logic [7:0] HALT_LIMIT = 8'(MCLK_HALT_CYCLES);
	localparam logic [7:0] HALT_COUNT_RST = 8'h00;
endpackage

// ===== rtl/clk_det_status.sv
// Audio clock detector status: measures MCLK, SCLK and LRCLK and
// reports the bit-clock ratio and presence flags in three registers whose measured fields are read-only, and the MCLK ratio code on o_mclk_ratio_code.
// Assumes clock pins and PLL lock arrive asynchronously; register
// port and PLL enable are synchronous to i_clk_sys.
// Notes on behaviour
// (RULE_01) Ratio code 1000, 1001, 1010 means 512, 768, 1024 MCLK per frame.
// (RULE_02) Codes 1011 to 1110 mean 1152, 1536, 2048, 3072 MCLK per frame.
// (RULE_03) Bit-clock count MSB sits in bit 0 at 0x5C, bits 7-1 reserved.
// (RULE_04) Low eight bits of the bit clocks per frame sit in 0x5D.
// (RULE_05) The bit-clock count is unreliable at one bit clock per frame.
// (RULE_06) Bit 6 at 0x5E is 1 while MCLK is halted, 0 while present.
// (RULE_07) Bit 5 at 0x5E is 1 when the PLL is unlocked or disabled.
// (RULE_08) A ratio matching no permitted value reports code 0000.
// (RULE_09) Measured fields update continuously and ignore host writes.
`timescale 1ns/1ps
module clk_det_status (
	// Clock, reset, enable
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Audio clock pins
	input wire logic i_mclk,
	input wire logic i_sclk,
	input wire logic i_lrclk,
	// PLL
	input wire logic i_pll_enable,
	input wire logic i_pll_locked,
	// Register port
	input wire logic [7:0] i_reg_addr,
	input wire logic i_reg_wr,
	input wire logic [7:0] i_reg_wdata,
	input wire logic i_reg_rd,
	output logic [7:0] o_reg_rdata,
	// Live ratio code
	output logic [3:0] o_mclk_ratio_code
);
	logic mclk_s;
	logic sclk_s;
	logic lrclk_s;
	logic pll_locked_s;
	logic mclk_prev_q;
	logic sclk_prev_q;
	logic lrclk_prev_q;
	logic mclk_rise;
	logic sclk_rise;
	logic frame_start;
	logic [12:0] mclk_cnt_q;
	logic [8:0] bclk_cnt_q;
	logic [3:0] mclk_ratio_code_q;
	logic [8:0] bitclk_per_frame_count_q;
	logic [7:0] halt_cnt_q;
	logic master_clock_missing_flag_q;
	logic pll_unlocked_flag_q;
	logic [6:0] high_reserved_q;
	logic status_reserved_q;
	logic [7:0] rdata_q;

	function automatic logic [3:0] ratio_to_code(input logic [12:0] n);
		logic [3:0] c;
		c = clk_det_pkg::CODE_ERROR; // RULE_08
		case (n)
			clk_det_pkg::RATIO_32: c = clk_det_pkg::CODE_32;
			clk_det_pkg::RATIO_48: c = clk_det_pkg::CODE_48;
			clk_det_pkg::RATIO_64: c = clk_det_pkg::CODE_64;
			clk_det_pkg::RATIO_128: c = clk_det_pkg::CODE_128;
			clk_det_pkg::RATIO_192: c = clk_det_pkg::CODE_192;
			clk_det_pkg::RATIO_256: c = clk_det_pkg::CODE_256;
			clk_det_pkg::RATIO_384: c = clk_det_pkg::CODE_384;
			clk_det_pkg::RATIO_512: c = clk_det_pkg::CODE_512; // RULE_01
			clk_det_pkg::RATIO_768: c = clk_det_pkg::CODE_768; // RULE_01
			clk_det_pkg::RATIO_1024: c = clk_det_pkg::CODE_1024; // RULE_01
			clk_det_pkg::RATIO_1152: c = clk_det_pkg::CODE_1152; // RULE_02
			clk_det_pkg::RATIO_1536: c = clk_det_pkg::CODE_1536; // RULE_02
			clk_det_pkg::RATIO_2048: c = clk_det_pkg::CODE_2048; // RULE_02
			clk_det_pkg::RATIO_3072: c = clk_det_pkg::CODE_3072; // RULE_02
			default: c = clk_det_pkg::CODE_ERROR; // RULE_08
		endcase
		return c;
	endfunction

	clk_det_sync u_sync_mclk (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_async(i_mclk),
		.o_level(mclk_s)
	);
	clk_det_sync u_sync_sclk (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_async(i_sclk),
		.o_level(sclk_s)
	);
	clk_det_sync u_sync_lrclk (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_async(i_lrclk),
		.o_level(lrclk_s)
	);
	clk_det_sync u_sync_pll (
		.i_clk_sys(i_clk_sys),
		.i_sys_rst(i_sys_rst),
		.i_ce(i_ce),
		.i_async(i_pll_locked),
		.o_level(pll_locked_s)
	);

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mclk_prev_q <= 1'b0;
			sclk_prev_q <= 1'b0;
			lrclk_prev_q <= 1'b0;
		end else if (i_ce) begin
			mclk_prev_q <= mclk_s;
			sclk_prev_q <= sclk_s;
			lrclk_prev_q <= lrclk_s;
		end
	end

	assign mclk_rise = mclk_s & ~mclk_prev_q;
	assign sclk_rise = sclk_s & ~sclk_prev_q;
	assign frame_start = lrclk_s & ~lrclk_prev_q;

	// Edge counters restart at each frame; they saturate so a stuck
	// LRCLK cannot wrap into a valid-looking ratio
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mclk_cnt_q <= clk_det_pkg::MCLK_COUNT_RST;
			bclk_cnt_q <= clk_det_pkg::BCLK_COUNT_RST;
		end else if (i_ce) begin
			if (frame_start) begin
				mclk_cnt_q <= 13'(mclk_rise);
				bclk_cnt_q <= 9'(sclk_rise);
			end else begin
				if (mclk_rise && !(&mclk_cnt_q)) begin
					mclk_cnt_q <= mclk_cnt_q + 13'h0001;
				end
				if (sclk_rise && !(&bclk_cnt_q)) begin
					bclk_cnt_q <= bclk_cnt_q + 9'h001;
				end
			end
		end
	end

	// Results refresh once per frame; accuracy at 1 FS not attempted
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mclk_ratio_code_q <= clk_det_pkg::RATIO_CODE_RST;
			bitclk_per_frame_count_q <= clk_det_pkg::BCLK_COUNT_RST;
		end else if (i_ce && frame_start) begin
			mclk_ratio_code_q <= ratio_to_code(mclk_cnt_q); // RULE_09
			bitclk_per_frame_count_q <= bclk_cnt_q; // RULE_04 RULE_05
		end
	end

	// MCLK halt: no rising edge for the halt time
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			halt_cnt_q <= clk_det_pkg::HALT_COUNT_RST;
			master_clock_missing_flag_q <= 1'b1;
		end else if (i_ce) begin
			if (mclk_rise) begin
				halt_cnt_q <= clk_det_pkg::HALT_COUNT_RST;
				master_clock_missing_flag_q <= 1'b0; // RULE_06
			end else if (halt_cnt_q >= clk_det_pkg::HALT_LIMIT) begin
				master_clock_missing_flag_q <= 1'b1; // RULE_06
			end else begin
				halt_cnt_q <= halt_cnt_q + 8'h01;
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pll_unlocked_flag_q <= 1'b1;
		end else if (i_ce) begin
			pll_unlocked_flag_q <= ~i_pll_enable | ~pll_locked_s; // RULE_07
		end
	end

	// Only reserved bits take writes; measured fields ignore them
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			high_reserved_q <= clk_det_pkg::RESERVED_RST[7:1];
			status_reserved_q <= clk_det_pkg::RESERVED_RST[7];
		end else if (i_ce && i_reg_wr) begin
			if (i_reg_addr == clk_det_pkg::REG_BCLK_RATIO_HIGH) begin
				high_reserved_q <= i_reg_wdata[7:1]; // RULE_03 RULE_09
			end else if (i_reg_addr == clk_det_pkg::REG_CLOCK_DET_STATUS) begin
				status_reserved_q <= i_reg_wdata[7]; // RULE_09
			end
		end
	end

	// Read data registered one cycle after the read strobe
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			rdata_q <= 8'h00;
		end else if (i_ce && i_reg_rd) begin
			if (i_reg_addr == clk_det_pkg::REG_BCLK_RATIO_HIGH) begin
				rdata_q <= {high_reserved_q,
					bitclk_per_frame_count_q[8]}; // RULE_03
			end else if (i_reg_addr == clk_det_pkg::REG_BCLK_RATIO_LOW) begin
				rdata_q <= bitclk_per_frame_count_q[7:0]; // RULE_04
			end else if (i_reg_addr == clk_det_pkg::REG_CLOCK_DET_STATUS) begin
				rdata_q <= {status_reserved_q,
					master_clock_missing_flag_q, // RULE_06
					pll_unlocked_flag_q, // RULE_07
					5'h00};
			end else begin
				rdata_q <= 8'h00;
			end
		end
	end

	assign o_reg_rdata = rdata_q;
	assign o_mclk_ratio_code = mclk_ratio_code_q;
endmodule

// ===== rtl/clk_det_sync.sv
// Three-stage input synchroniser with agreement filter.
// Assumes an asynchronous input and a single system clock.
`timescale 1ns/1ps
module clk_det_sync (
	// Clock and reset
	input wire logic i_clk_sys,
	input wire logic i_sys_rst,
	input wire logic i_ce,
	// Async input and filtered level
	input wire logic i_async,
	output logic o_level
);
	logic s1_q;
	logic s2_q;
	logic s3_q;
	logic level_q;

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			s1_q <= 1'b0;
			s2_q <= 1'b0;
			s3_q <= 1'b0;
		end else if (i_ce) begin
			s1_q <= i_async;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Only a change seen by both later stages is taken
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			level_q <= 1'b0;
		end else if (i_ce && (s2_q == s3_q)) begin
			level_q <= s3_q;
		end
	end

	assign o_level = level_q;
endmodule
